// *** verilog/sarp_pkg.sv ***
package sarp_pkg;
   localparam int          CLK_PERIOD_NS    = 100;
   localparam int          CONV_TIME_NS     = 650;
   // longest time rounds down
   localparam int          CONV_CYCLES      = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int          RESUME_TIME_NS   = 20;
   localparam int          RESUME_CYCLES    = (RESUME_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                              RESUME_TIME_NS / CLK_PERIOD_NS;
   localparam int          ABORT_TIME_NS    = 50;
   localparam int          SELF_RST_CYCLES  = 1;
   localparam int          POR_CYCLES       = 4;
   localparam int          CNT_W            = 4;
   localparam logic [15:0] RESULT_RESET     = 16'h0000;
   localparam logic [7:0]  LOW_BYTE_FILL    = 8'hFF;

   typedef enum logic [1:0] {
      SARP_RESET  = 2'b00,
      SARP_SAMPLE = 2'b01,
      SARP_HOLD   = 2'b10,
      SARP_CONV   = 2'b11
   } sarp_state_t;
endpackage : sarp_pkg

// *** verilog/sarp_sync.sv ***
`timescale 1ns/1ps
module sarp_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   input  wire logic [W-1:0] rst_val_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] stage1;

   // reset loads all ones at each instance; rst_val_i is not used
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stage1 <= '1;
         q_o    <= '1;
      end else begin
         stage1 <= d_i;
         q_o    <= stage1;
      end
   end
endmodule : sarp_sync

// *** verilog/sarp_adc_readout.sv ***
`timescale 1ns/1ps
module sarp_adc_readout
   import sarp_pkg::*;
#(
   parameter int CONV_CNT = CONV_CYCLES
) (
   // clock and system reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // host pins
   input  wire logic        reset_pin_n_i,
   input  wire logic        convert_start_n_i,
   input  wire logic        chip_sel_n_i,
   input  wire logic        out_en_n_i,
   input  wire logic        byte_sel_i,
   // converter core
   input  wire logic [15:0] sample_code_i,
   output logic             hold_o,
   // status and bus
   output logic             busy_o,
   output logic [15:0]      data_pins_o,
   output logic [15:0]      data_pins_oe_o
);
   logic [4:0]  pins_s;
   logic        reset_n_s, conv_n_s, cs_n_s, rd_n_s, byte_s;
   logic        conv_n_d, cs_n_d;
   logic        conv_fall, cs_fall;
   sarp_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] por_cnt;
   logic        por_done;
   logic        self_rst;
   logic        in_reset;
   logic [15:0] result;
   logic        first_sample;

   // pins pass two flops before use
   sarp_sync #(.W(5)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .d_i       ({reset_pin_n_i, convert_start_n_i, chip_sel_n_i, out_en_n_i, ~byte_sel_i}),
      .rst_val_i (5'h1F),
      .q_o       (pins_s)
   );
   assign reset_n_s = pins_s[4];
   assign conv_n_s  = pins_s[3];
   assign cs_n_s    = pins_s[2];
   assign rd_n_s    = pins_s[1];
   assign byte_s    = ~pins_s[0];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_n_d <= 1'b1;
         cs_n_d   <= 1'b1;
      end else begin
         conv_n_d <= conv_n_s;
         cs_n_d   <= cs_n_s;
      end
   end
   assign conv_fall = conv_n_d & ~conv_n_s;
   assign cs_fall   = cs_n_d & ~cs_n_s;

   // internal power-on reset stretch
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         por_cnt  <= '0;
         por_done <= 1'b0;
      end else if (!por_done) begin
         por_cnt  <= por_cnt + 1'b1;
         por_done <= (por_cnt == CNT_W'(POR_CYCLES - 1));
      end
   end

   // self-clearing abort, needs no release from host
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         self_rst <= 1'b0;
      end else begin
         self_rst <= (state == SARP_CONV) &&
                     ((conv_fall && !cs_n_s) || cs_fall);
      end
   end

   // pin reset works regardless of select; two-flop sync delay (200 ns) exceeds ABORT_TIME_NS
   assign in_reset = !reset_n_s || !por_done || self_rst;

   // conversion sequencer on internal clock only
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state        <= SARP_RESET;
         cnt          <= '0;
         first_sample <= 1'b1;
      end else if (in_reset) begin
         state        <= SARP_RESET;
         cnt          <= '0;
         first_sample <= 1'b1;
      end else begin
         unique case (state)
            SARP_RESET: begin
               cnt <= cnt + 1'b1;
               if (cnt == CNT_W'(RESUME_CYCLES - 1)) begin
                  state <= SARP_SAMPLE;
                  cnt   <= '0;
               end
            end
            SARP_SAMPLE: begin
               if (conv_fall && !cs_n_s) begin
                  state        <= SARP_CONV;
                  first_sample <= 1'b0;
                  cnt          <= '0;
               end
            end
            SARP_CONV: begin
               cnt <= cnt + 1'b1;
               if (cnt == CNT_W'(CONV_CNT - 1)) begin
                  state <= cs_n_s ? SARP_HOLD : SARP_SAMPLE;
                  cnt   <= '0;
               end
            end
            SARP_HOLD: begin
               // sampling waits for select fall when busy already low
               if (!cs_n_s) begin
                  state <= SARP_SAMPLE;
               end
            end
         endcase
      end
   end

   // result latch: latest completed conversion
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         result <= RESULT_RESET;
      end else if (in_reset) begin
         result <= RESULT_RESET;
      end else if (state == SARP_CONV && cnt == CNT_W'(CONV_CNT - 1)) begin
         result <= sample_code_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         hold_o <= 1'b0;
      end else begin
         busy_o <= !in_reset && ((state == SARP_SAMPLE && conv_fall && !cs_n_s) ||
                   (state == SARP_CONV && cnt != CNT_W'(CONV_CNT - 1)));
         hold_o <= !in_reset && ((state == SARP_SAMPLE && conv_fall && !cs_n_s) ||
                   (state == SARP_CONV && cnt != CNT_W'(CONV_CNT - 1)));
      end
   end

   // bus output, byte select works with enable held or toggled
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_pins_o    <= RESULT_RESET;
         data_pins_oe_o <= 16'h0000;
      end else begin
         data_pins_oe_o <= (!cs_n_s && !rd_n_s) ? 16'hFFFF : 16'h0000;
         if (byte_s) begin
            data_pins_o <= {result[7:0], LOW_BYTE_FILL};
         end else begin
            data_pins_o <= result;
         end
      end
   end
endmodule : sarp_adc_readout

// *** dv/sarp_host_model.sv ***
`timescale 1ns/1ps
module sarp_host_model (
   input  wire logic        ref_clk_i,
   input  wire logic [15:0] drv_i,
   input  wire logic [15:0] oe_i,
   output logic      [15:0] bus_o
);
   logic [15:0] last = 16'h0000;
   // no pull on the bus: a released pin shows the inverse of its last level
   assign bus_o = (drv_i & oe_i) | (~last & ~oe_i);
   always_ff @(posedge ref_clk_i) last <= bus_o;
endmodule : sarp_host_model

// *** dv/sarp_adc_readout_props.sv ***
`timescale 1ns/1ps
module sarp_adc_readout_chk (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        reset_pin_n_i,
   input wire logic        convert_start_n_i,
   input wire logic        chip_sel_n_i,
   input wire logic        out_en_n_i,
   input wire logic        byte_sel_i,
   input wire logic        hold_o,
   input wire logic        busy_o,
   input wire logic [15:0] data_pins_o,
   input wire logic [15:0] data_pins_oe_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   AST_OE_WHOLE: assert property (data_pins_oe_o == 16'h0000 || data_pins_oe_o == 16'hFFFF)
      else $error("bus enable split");
   AST_OE_ON: assert property ((!chip_sel_n_i && !out_en_n_i)[*5] |-> &data_pins_oe_o)
      else $error("bus not driven");
   AST_OE_OFF: assert property ((chip_sel_n_i || out_en_n_i)[*5] |-> !data_pins_oe_o)
      else $error("bus driven while off");
   AST_BUSY_RISE: assert property ($fell(convert_start_n_i) && !chip_sel_n_i && !busy_o
      |-> ##[1:4] busy_o) else $error("busy missing");
   AST_BUSY_LEN: assert property ($rose(busy_o) |-> ##6 !busy_o)
      else $error("conversion too long");
   AST_HOLD: assert property (busy_o |-> hold_o)
      else $error("not holding");
   AST_CS_ABORT: assert property ($fell(chip_sel_n_i) && busy_o |-> ##[1:5] !busy_o)
      else $error("select abort missed");
   AST_CV_ABORT: assert property ($fell(convert_start_n_i) && !chip_sel_n_i && busy_o
      |-> ##[1:5] !busy_o) else $error("start abort missed");
   AST_PIN_RST: assert property (!reset_pin_n_i[*5] |-> !busy_o)
      else $error("reset pin ignored");
   AST_LOW_FILL: assert property (byte_sel_i[*5] ##0 data_pins_oe_o[0]
      |-> data_pins_o[7:0] == 8'hFF) else $error("low pins not ones");
endmodule : sarp_adc_readout_chk

bind sarp_adc_readout sarp_adc_readout_chk chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .reset_pin_n_i(reset_pin_n_i), .convert_start_n_i(convert_start_n_i),
   .chip_sel_n_i(chip_sel_n_i), .out_en_n_i(out_en_n_i), .byte_sel_i(byte_sel_i),
   .hold_o(hold_o), .busy_o(busy_o), .data_pins_o(data_pins_o),
   .data_pins_oe_o(data_pins_oe_o));

// *** dv/sar_adc_parallel_readout_tb.sv ***
`timescale 1ns/1ps
module sar_adc_parallel_readout_tb;
   localparam int CONV = 6;
   logic        ref_clk_i = 1'b0, rst_i = 1'b1, rst_n = 1'b1, cv_n = 1'b1, busy;
   logic        cs_n = 1'b1, oe_n = 1'b1, bs = 1'b0, hold;
   logic [15:0] code = 16'h0000, dq, oe, bus;
   logic [15:0] codes [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
   int          miscompares = 0, num_checks = 0, cyc_cnt = 0, n;
   always #50 ref_clk_i = ~ref_clk_i;
   sarp_adc_readout #(.CONV_CNT(CONV)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .reset_pin_n_i(rst_n), .convert_start_n_i(cv_n), .chip_sel_n_i(cs_n),
      .out_en_n_i(oe_n), .byte_sel_i(bs), .sample_code_i(code), .hold_o(hold),
      .busy_o(busy), .data_pins_o(dq), .data_pins_oe_o(oe));
   sarp_host_model host (.ref_clk_i(ref_clk_i), .drv_i(dq), .oe_i(oe), .bus_o(bus));
   task automatic cyc(int k);
      repeat (k) @(negedge ref_clk_i);
   endtask : cyc
   task automatic chk(string s, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s exp %h got %h", s, e, g);
         miscompares++;
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   // enable goes high a cycle ahead of convert start to keep reads clear of it
   task automatic start(logic [15:0] c);
      code = c;
      oe_n = 1'b1;
      cs_n = 1'b0;
      cyc(1);
      cv_n = 1'b0;
      cyc(1);
      cv_n = 1'b1;
      for (n = 0; n < 6 && busy !== 1'b1; n++) cyc(1);
      chk("busy", 16'h1, {15'h0, busy});
      chk("hold", 16'h1, {15'h0, hold});
   endtask : start
   task automatic convert(logic [15:0] c);
      start(c);
      for (n = 0; n < 20 && busy === 1'b1; n++) cyc(1);
      chk("busy len", 16'(CONV), 16'(n));
   endtask : convert
   task automatic rd(logic b, logic [15:0] e, string s);
      bs = b;
      cs_n = 1'b0;
      oe_n = 1'b0;
      cyc(5);
      chk(s, e, bus);
   endtask : rd
   always @(posedge ref_clk_i) begin
      cyc_cnt++;
      if (cyc_cnt > 3000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      cyc(10);
      rst_i = 1'b0;
      cyc(10);
      // flush registers before trusting results
      repeat (3) convert(16'h0000);
      foreach (codes[i]) begin
         convert(codes[i]);
         rd(1'b0, codes[i], "word");
         rd(1'b1, {codes[i][7:0], 8'hFF}, "low byte");
      end
      // select high at the end parks sampling until select falls
      start(16'h5555);
      cs_n = 1'b1;
      for (n = 0; n < 20 && busy === 1'b1; n++) cyc(1);
      chk("busy held", 16'h0, {15'h0, busy});
      rd(1'b0, 16'h5555, "held word");
      oe_n = 1'b1;
      cyc(5);
      rd(1'b1, {8'h55, 8'hFF}, "toggled low byte");
      convert(16'h6666);
      rd(1'b0, 16'h6666, "after hold");
      cs_n = 1'b1;
      cyc(5);
      chk("bus off", 16'h0000, oe);
      start(16'h1234);
      cs_n = 1'b1;
      cyc(1);
      cs_n = 1'b0;
      cyc(5);
      chk("select abort", 16'h0, {15'h0, busy});
      rd(1'b0, 16'h0000, "cleared");
      convert(16'h0F0F);
      rd(1'b0, 16'h0F0F, "resumed");
      start(16'h2222);
      cyc(1);
      cv_n = 1'b0;
      cyc(1);
      cv_n = 1'b1;
      cyc(4);
      chk("start abort", 16'h0, {15'h0, busy});
      rd(1'b0, 16'h0000, "cleared");
      start(16'h3333);
      rst_n = 1'b0;
      cyc(5);
      chk("pin abort", 16'h0, {15'h0, busy});
      rst_n = 1'b1;
      cyc(5);
      convert(16'h4444);
      rd(1'b0, 16'h4444, "after reset");
      test_done();
   end
endmodule : sar_adc_parallel_readout_tb
